// *** core/ipt_divider.sv ***
/*
 * Oscillator tick generator and binary divider chain with one-second tick.
 * Assumes clk is far faster than the oscillator rate and that clear is a clk pulse.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ipt_regs.svh"

module ipt_divider #(
    parameter int OSC_HZ = `IPT_OSC_HZ,
    parameter int CLK_HZ = `IPT_CLK_HZ
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     clear,
    output logic                          osc_tick,
    output logic [`IPT_DIV_BITS-1:0]      div_taps,
    output logic                          sec_tick
);

    logic [31:0] acc_ff;
    logic [31:0] nxt_acc;
    logic        nxt_tick;

    generate
        if (OSC_HZ < 1 || OSC_HZ * 2 > CLK_HZ) begin : g_chk
            $error("ipt_divider needs clk at least twice the oscillator rate");
        end
    endgenerate

    // Fractional accumulator stands in for the crystal: mean rate exact, jitter one clk
    always_comb begin
        nxt_acc  = acc_ff + 32'(OSC_HZ);
        nxt_tick = 1'b0;
        if (nxt_acc >= 32'(CLK_HZ)) begin
            nxt_acc  = nxt_acc - 32'(CLK_HZ);
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff   <= 32'h0;
            osc_tick <= 1'b0;
        end else begin
            acc_ff   <= nxt_acc;
            osc_tick <= nxt_tick;
        end
    end

    // Common clear keeps every tap and the second in phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_taps <= '0;
            sec_tick <= 1'b0;
        end else if (clear) begin
            div_taps <= '0;
            sec_tick <= 1'b0;
        end else begin
            if (osc_tick) begin
                div_taps <= div_taps + 1'b1;
            end
            sec_tick <= osc_tick & (&div_taps);
        end
    end

endmodule

`default_nettype wire

// *** core/ipt_pkg.sv ***
/*
 * Types shared by the interval pulse and seconds timer: the setting register layout,
 * the serial state encoding and the sampled pin group.
 * Assumes nothing of its surroundings.
 */
package ipt_pkg;

    typedef struct packed {
        logic [9:0] freq_select;
        logic       spare;
        logic       filler_bit_high;
        logic       filler_bit_low;
        logic [2:0] timer_clear_code;
    } ipt_setting_t;

    typedef enum logic [2:0] {
        IPT_ST_IDLE = 3'h0,
        IPT_ST_ADDR = 3'h1,
        IPT_ST_AACK = 3'h3,
        IPT_ST_WRX  = 3'h2,
        IPT_ST_WACK = 3'h6,
        IPT_ST_TX   = 3'h7,
        IPT_ST_MACK = 3'h5
    } ipt_state_t;

    typedef struct packed {
        logic gate;
        logic sda;
        logic scl;
    } ipt_pins_t;

endpackage

// *** core/ipt_regs.svh ***
/*
 * Constants of the interval pulse and seconds timer: serial address, field positions of
 * the setting register, reset values and oscillator timing.
 * Assumes it is included by its bare name from every file that needs a figure.
 */
`ifndef IPT_REGS_SVH
`define IPT_REGS_SVH

`define IPT_SLAVE_ADDR     7'h32
`define IPT_DIR_READ       1'h1
`define IPT_PTR_BIT        7
`define IPT_CLEAR_CODE     3'h2
`define IPT_FREQ_MSB       15
`define IPT_FREQ_LSB       6
`define IPT_FREQ_BITS      10
`define IPT_CLR_MSB        2
`define IPT_SET_RESET      16'h0000
`define IPT_CNT_RESET      24'h000000
`define IPT_CNT_MAX        24'hFFFFFF
`define IPT_FILL_BYTE      8'hFF
`define IPT_TIME_BYTES     3
`define IPT_SET_BYTES      2
`define IPT_OSC_HZ         32768
`define IPT_CLK_HZ         125000000
`define IPT_POWERUP_MS     500
`define IPT_DIV_BITS       15
`define IPT_TAP_LOW_BIT    4

`endif

// *** core/ipt_sync.sv ***
/*
 * Two flip-flop synchroniser for a group of levels from outside the clock domain.
 * Assumes each bit is a slow level or a clock far slower than clk.
 */
`timescale 1ns/10ps
`default_nettype none

module ipt_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_ff;

    generate
        if (W < 1) begin : g_chk
            $error("ipt_sync needs a width of at least one");
        end
    endgenerate

    // Only the second stage is visible outside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end

endmodule

`default_nettype wire

// *** core/ipt_timer.sv ***
/*
 * Interval pulse generator with elapsed-seconds counter behind a serial target port.
 * Assumes an open-drain data pin resolved outside (sda_oe high pulls low), a serial
 * clock far slower than clk, and the gate pin as an asynchronous level.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ipt_regs.svh"

module ipt_timer #(
    parameter int       OSC_HZ     = `IPT_OSC_HZ,
    parameter int       CLK_HZ     = `IPT_CLK_HZ,
    parameter int       POWERUP_MS = `IPT_POWERUP_MS,
    parameter bit [6:0] SLAVE_ADDR = `IPT_SLAVE_ADDR
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    input  wire logic output_gate_input,
    output logic      pulse_out
);

    // ******************************************************************
    // Timing figures and declarations
    // ******************************************************************
    localparam int POWERUP_TICKS = (OSC_HZ * POWERUP_MS) / 1000;
    localparam int HOLD_W        = $clog2(POWERUP_TICKS + 1);
    localparam int DW            = `IPT_DIV_BITS;

    generate
        if (POWERUP_TICKS < 1) begin : g_chk_hold
            $error("ipt_timer power-up hold must last at least one oscillator tick");
        end
        if (`IPT_TAP_LOW_BIT + `IPT_FREQ_BITS > DW) begin : g_chk_taps
            $error("ipt_timer divider too short for the tap set");
        end
    endgenerate

    logic                      rst_meta_ff;
    logic                      rst_n_ff;
    ipt_pkg::ipt_pins_t        pins_s;
    logic                      scl_q_ff;
    logic                      sda_q_ff;
    logic                      scl_rise;
    logic                      scl_fall;
    logic                      bus_start;
    logic                      bus_stop;
    ipt_pkg::ipt_state_t       state_ff;
    logic [3:0]                bit_cnt_ff;
    logic [7:0]                shift_ff;
    logic [7:0]                tx_ff;
    logic                      dir_read_ff;
    logic                      nack_ff;
    logic [1:0]                wr_idx_ff;
    logic [1:0]                rd_idx_ff;
    logic                      ptr_set_ff;
    logic                      rd_use_set_ff;
    logic [7:0]                hi_byte_ff;
    logic [23:0]               snap_ff;
    logic                      rx_done;
    logic                      commit;
    logic                      rd_use_set_now;
    ipt_pkg::ipt_setting_t     setting_ff;
    logic [23:0]               elapsed_count_bits;
    logic [HOLD_W-1:0]         hold_cnt_ff;
    logic                      hold_done_ff;
    logic                      osc_tick;
    logic [DW-1:0]             div_taps;
    logic                      sec_tick;
    logic [`IPT_FREQ_BITS-1:0] tap_vec;

    // ******************************************************************
    // Reset release and pin sampling
    // ******************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    ipt_sync #(
        .W (3)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n_ff),
        .d     ({output_gate_input, sda_i, scl_i}),
        .q     (pins_s)
    );

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            scl_q_ff <= 1'b0;
            sda_q_ff <= 1'b0;
        end else begin
            scl_q_ff <= pins_s.scl;
            sda_q_ff <= pins_s.sda;
        end
    end

    assign scl_rise  = pins_s.scl & ~scl_q_ff;
    assign scl_fall  = ~pins_s.scl & scl_q_ff;
    // Data moving while the clock is high frames the transfer
    assign bus_start = pins_s.scl & scl_q_ff & sda_q_ff & ~pins_s.sda;
    assign bus_stop  = pins_s.scl & scl_q_ff & ~sda_q_ff & pins_s.sda;

    // ******************************************************************
    // Serial target: read byte selection and state machine
    // ******************************************************************
    function automatic logic [7:0] pick_byte(
        input logic [1:0]  idx,
        input logic        use_set,
        input logic [15:0] set_val,
        input logic [23:0] cnt_val
    );
        logic [7:0] b;
        b = `IPT_FILL_BYTE;
        if (use_set && idx < 2'h2) begin
            b = set_val[8 * (1 - idx) +: 8];
        end else if (!use_set && idx != 2'h3) begin
            b = cnt_val[8 * (2 - idx) +: 8];
        end
        return b;
    endfunction

    // Gate low diverts setting reads to the counter
    assign rd_use_set_now = ptr_set_ff & pins_s.gate;

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff    <= ipt_pkg::IPT_ST_IDLE;
            bit_cnt_ff  <= 4'h0;
            shift_ff    <= 8'h00;
            tx_ff       <= 8'hFF;
            dir_read_ff <= 1'b0;
            nack_ff     <= 1'b0;
            wr_idx_ff   <= 2'h0;
            rd_idx_ff   <= 2'h0;
        end else if (bus_start) begin
            state_ff   <= ipt_pkg::IPT_ST_ADDR;
            bit_cnt_ff <= 4'h0;
            wr_idx_ff  <= 2'h0;
            tx_ff      <= 8'hFF;
        end else if (bus_stop) begin
            state_ff <= ipt_pkg::IPT_ST_IDLE;
            tx_ff    <= 8'hFF;
        end else begin
            case (state_ff)
                ipt_pkg::IPT_ST_ADDR, ipt_pkg::IPT_ST_WRX: begin
                    if (scl_rise) begin
                        shift_ff   <= {shift_ff[6:0], pins_s.sda};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                        if (state_ff == ipt_pkg::IPT_ST_WRX) begin
                            state_ff <= ipt_pkg::IPT_ST_WACK;
                            if (wr_idx_ff != 2'h3) begin
                                wr_idx_ff <= wr_idx_ff + 2'h1;
                            end
                        end else if (shift_ff[7:1] == SLAVE_ADDR) begin
                            state_ff    <= ipt_pkg::IPT_ST_AACK;
                            dir_read_ff <= (shift_ff[0] == `IPT_DIR_READ);
                        end else begin
                            state_ff <= ipt_pkg::IPT_ST_IDLE;
                        end
                    end
                end
                ipt_pkg::IPT_ST_AACK: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        if (dir_read_ff) begin
                            state_ff  <= ipt_pkg::IPT_ST_TX;
                            tx_ff     <= pick_byte(2'h0, rd_use_set_now, setting_ff,
                                                   elapsed_count_bits);
                            rd_idx_ff <= 2'h1;
                        end else begin
                            state_ff <= ipt_pkg::IPT_ST_WRX;
                        end
                    end
                end
                ipt_pkg::IPT_ST_WACK: begin
                    if (scl_fall) begin
                        state_ff   <= ipt_pkg::IPT_ST_WRX;
                        bit_cnt_ff <= 4'h0;
                    end
                end
                ipt_pkg::IPT_ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_ff == 4'h8) begin
                            state_ff <= ipt_pkg::IPT_ST_MACK;
                            tx_ff    <= 8'hFF;
                        end else begin
                            tx_ff <= {tx_ff[6:0], 1'b1};
                        end
                    end
                end
                ipt_pkg::IPT_ST_MACK: begin
                    if (scl_rise) begin
                        nack_ff <= pins_s.sda;
                    end else if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        if (nack_ff) begin
                            state_ff <= ipt_pkg::IPT_ST_IDLE;
                        end else begin
                            state_ff <= ipt_pkg::IPT_ST_TX;
                            tx_ff    <= pick_byte(rd_idx_ff, rd_use_set_ff, setting_ff,
                                                  snap_ff);
                            if (rd_idx_ff != 2'h3) begin
                                rd_idx_ff <= rd_idx_ff + 2'h1;
                            end
                        end
                    end
                end
                default: begin
                    state_ff <= ipt_pkg::IPT_ST_IDLE;
                end
            endcase
        end
    end

    // Open drain: only ever pulls low
    assign sda_o  = 1'b0;
    assign sda_oe = (state_ff == ipt_pkg::IPT_ST_AACK) |
                    (state_ff == ipt_pkg::IPT_ST_WACK) |
                    ((state_ff == ipt_pkg::IPT_ST_TX) & ~tx_ff[7]);

    // Counter frozen at address time so the three bytes agree
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            snap_ff       <= `IPT_CNT_RESET;
            rd_use_set_ff <= 1'b0;
        end else if (state_ff == ipt_pkg::IPT_ST_AACK && scl_fall && dir_read_ff &&
                     !bus_start && !bus_stop) begin
            snap_ff       <= elapsed_count_bits;
            rd_use_set_ff <= rd_use_set_now;
        end
    end

    assign rx_done = scl_fall & (state_ff == ipt_pkg::IPT_ST_WRX) & (bit_cnt_ff == 4'h8) &
                     ~bus_start & ~bus_stop;

    // Stop forgets the pointer, so a plain read returns the counter
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ptr_set_ff <= 1'b0;
        end else if (bus_stop) begin
            ptr_set_ff <= 1'b0;
        end else if (rx_done && wr_idx_ff == 2'h0) begin
            ptr_set_ff <= ~shift_ff[`IPT_PTR_BIT];
        end
    end

    // ******************************************************************
    // Setting register
    // ******************************************************************
    // Only the third data byte (second setting byte) commits, so a lone dummy write changes nothing
    assign commit = rx_done & (wr_idx_ff == 2'h2);

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            hi_byte_ff <= 8'h00;
            setting_ff <= `IPT_SET_RESET;
        end else if (rx_done && wr_idx_ff == 2'h1) begin
            hi_byte_ff <= shift_ff;
        end else if (commit) begin
            // Clear code is stored beside, never instead of, the select bits
            setting_ff <= {hi_byte_ff, shift_ff};
        end
    end

    // ******************************************************************
    // Dividers, power-up hold and seconds counter
    // ******************************************************************
    // Each committed setting write restarts taps and second alike
    ipt_divider #(
        .OSC_HZ (OSC_HZ),
        .CLK_HZ (CLK_HZ)
    ) u_div (
        .clk      (clk),
        .rst_n    (rst_n_ff),
        .clear    (commit),
        .osc_tick (osc_tick),
        .div_taps (div_taps),
        .sec_tick (sec_tick)
    );

    // Oscillator settling window, counted in oscillator ticks
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            hold_cnt_ff  <= '0;
            hold_done_ff <= 1'b0;
        end else if (!hold_done_ff && osc_tick) begin
            if (hold_cnt_ff == HOLD_W'(POWERUP_TICKS - 1)) begin
                hold_done_ff <= 1'b1;
            end
            hold_cnt_ff <= hold_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            elapsed_count_bits <= `IPT_CNT_RESET;
        end else if (commit && shift_ff[`IPT_CLR_MSB:0] == `IPT_CLEAR_CODE) begin
            elapsed_count_bits <= `IPT_CNT_RESET;
        end else if (sec_tick && elapsed_count_bits != `IPT_CNT_MAX) begin
            elapsed_count_bits <= elapsed_count_bits + 24'h000001;
        end
    end

    // ******************************************************************
    // Periodic output
    // ******************************************************************
    // Highest select bit is the fastest tap; inverted so each tap starts high
    generate
        for (genvar g = 0; g < `IPT_FREQ_BITS; g = g + 1) begin : g_tap
            assign tap_vec[g] = ~div_taps[`IPT_TAP_LOW_BIT + `IPT_FREQ_BITS - 1 - g];
        end
    endgenerate

    // Gate is taken live, so a toggle may clip the pulse in flight
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pulse_out <= 1'b0;
        end else if (!hold_done_ff) begin
            pulse_out <= 1'b0;
        end else if (!pins_s.gate) begin
            pulse_out <= 1'b1;
        end else if (setting_ff.freq_select == '0) begin
            pulse_out <= 1'b0;
        end else begin
            // Counter state takes no part here
            pulse_out <= &(tap_vec | ~setting_ff.freq_select);
        end
    end

endmodule

`default_nettype wire

// *** test/ipt_checker.sv ***
/* Pin checker for ipt_timer.
   Bound to every ipt_timer instance. */
`timescale 1ns/10ps
`default_nettype none
module ipt_checker #(
    parameter int OSC_HZ     = 32768,
    parameter int CLK_HZ     = 125000000,
    parameter int POWERUP_MS = 500
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic output_gate_input,
    input wire logic pulse_out
);
    // Hold in clk; margins cover reset flops and tick slop
    localparam int HOLD = CLK_HZ / 1000 * POWERUP_MS;
    int   hcnt;
    int   oecnt;
    logic frame_ff;
    logic done;
    assign done = hcnt > HOLD + 64;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) hcnt <= 0;
        else if (!done) hcnt <= hcnt + 1;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) oecnt <= 0;
        else oecnt <= sda_oe ? oecnt + 1 : 0;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) frame_ff <= 1'b0;
        else if (scl_i && $past(scl_i) && $fell(sda_i)) frame_ff <= 1'b1;
        else if (scl_i && $past(scl_i) && $rose(sda_i)) frame_ff <= 1'b0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_HOLD_LOW: assert property (hcnt < HOLD - 16 |-> !pulse_out)
        else $error("pulse during hold");
    AST_GATE_LOW: assert property ((done && !output_gate_input) [*5] |-> pulse_out)
        else $error("gate low, pulse low");
    AST_GATE_FALL: assert property (done && $fell(output_gate_input) |-> ##[1:4] pulse_out)
        else $error("gate fall not followed");
    AST_SDA_O_ZERO: assert property (sda_o == 1'b0)
        else $error("data drive not zero");
    AST_RESET_QUIET: assert property ($rose(resetn) |-> !pulse_out && !sda_oe)
        else $error("outputs active at reset");
    AST_IDLE_NO_OE: assert property (!frame_ff |-> !sda_oe)
        else $error("data pulled outside frame");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data changed with clock high");
    AST_OE_BOUND: assert property (oecnt < 200)
        else $error("data held low too long");
    cover property (done && output_gate_input && $rose(pulse_out));
    cover property (frame_ff && $rose(sda_oe));
    cover property ($fell(frame_ff));
endmodule
bind ipt_timer ipt_checker #(
    .OSC_HZ(OSC_HZ), .CLK_HZ(CLK_HZ), .POWERUP_MS(POWERUP_MS)
) chk (
    .clk(clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .output_gate_input(output_gate_input), .pulse_out(pulse_out)
);
`default_nettype wire

// *** test/ipt_host.sv ***
/* Serial bus host model.
   Assumes a pull-up on data; the bench calls its tasks. */
`timescale 1ns/10ps
`default_nettype none
module ipt_host (
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_pull,
    output logic [7:0]      rx_byte,
    output logic            rx_stb
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        rx_byte = 8'h00;
        rx_stb = 1'b0;
    end
    // Data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_pull = ~b;
        #31.25 scl = 1'b1;
        #31.25 r = sda;
        #31.25 scl = 1'b0;
        #31.25;
    endtask
    task automatic start;
        sda_pull = 1'b0;
        #31.25 scl = 1'b1;
        #31.25 sda_pull = 1'b1;
        #31.25 scl = 1'b0;
        #31.25;
    endtask
    task automatic stop;
        sda_pull = 1'b1;
        #31.25 scl = 1'b1;
        #31.25 sda_pull = 1'b0;
        #31.25;
    endtask
    task automatic put(input logic [7:0] d, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ok = ok & ~r;
    endtask
    task automatic probe(input logic [7:0] a, output logic ok);
        ok = 1'b1;
        start;
        put(a, ok);
        stop;
    endtask
    task automatic wr_set(input logic [15:0] v, output logic ok);
        ok = 1'b1;
        start;
        put(8'h64, ok);
        put(8'h01, ok);
        put(v[15:8], ok);
        put(v[7:0], ok);
        stop;
    endtask
    task automatic rd(input logic ptr, input int n, output logic ok);
        logic [7:0] d;
        logic       r;
        ok = 1'b1;
        start;
        if (ptr) begin
            put(8'h64, ok);
            put(8'h01, ok);
            start;
        end
        put(8'h65, ok);
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
            bit_io(k == n - 1, r);
            rx_byte = d;
            rx_stb = 1'b1;
            #1 rx_stb = 1'b0;
        end
        stop;
    endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
/* Bench for the interval pulse and seconds timer.
   Assumes ipt_host and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk;
    logic        resetn;
    logic        gate;
    logic        sda_oe;
    logic        scl;
    logic        pull;
    logic        pulse;
    logic        rx_stb;
    logic [7:0]  rx_byte;
    logic [7:0]  exp_q[$];
    logic        ok;
    logic [15:0] rnd;
    logic [15:0] val;
    int          err_count;
    int          num_checks;
    int          cyc;
    int          hi;
    wire  logic  sda = ~(pull | sda_oe);
    // Fast oscillator and short hold keep the run short
    ipt_timer #(.OSC_HZ(2000000), .CLK_HZ(4000000), .POWERUP_MS(1)) uut (
        .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe(sda_oe), .output_gate_input(gate), .pulse_out(pulse));
    ipt_host host (.sda(sda), .scl(scl), .sda_pull(pull), .rx_byte(rx_byte),
        .rx_stb(rx_stb));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        check("pending notes", 24'h0, 24'(exp_q.size()));
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic set_gate(input logic g);
        @(negedge clk) gate = g;
        wait_clk(8);
    endtask
    task automatic duty(output int h);
        h = 0;
        repeat (2048) @(negedge clk) h += pulse;
    endtask
    task automatic push3(input logic [23:0] c);
        exp_q.push_back(c[23:16]);
        exp_q.push_back(c[15:8]);
        exp_q.push_back(c[7:0]);
    endtask
    always @(posedge rx_stb) begin
        if (exp_q.size() == 0) check("spare byte", 24'h0, 24'h1);
        else check("read byte", exp_q.pop_front(), rx_byte);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            err_count++;
            complete_run;
        end
    end
    initial begin
        resetn = 1'b0;
        gate = 1'b0;
        rnd = 16'h8BD2;
        wait_clk(4);
        resetn = 1'b1;
        wait_clk(200);
        check("hold pulse", 1'b0, pulse);
        push3(24'h0);
        exp_q.push_back(8'hFF);
        host.rd(1'b0, 4, ok);
        check("count ack", 1'b1, ok);
        host.probe(8'h66, ok);
        check("foreign ack", 1'b0, ok);
        wait_clk(4000);
        check("gate low pulse", 1'b1, pulse);
        set_gate(1'b1);
        check("unset pulse", 1'b0, pulse);
        set_gate(1'b0);
        host.wr_set(16'h8002, ok);
        check("gated write", 1'b1, pulse);
        check("write ack", 1'b1, ok);
        set_gate(1'b1);
        duty(hi);
        check("single tap duty", 1024, hi);
        rnd = lfsr(rnd);
        val = {10'h300, rnd[2:0], 3'h7};
        host.wr_set(val, ok);
        duty(hi);
        check("two tap duty", 512, hi);
        exp_q.push_back(val[15:8]);
        exp_q.push_back(val[7:0]);
        host.rd(1'b1, 2, ok);
        check("set read ack", 1'b1, ok);
        set_gate(1'b0);
        push3(24'h0);
        host.rd(1'b1, 3, ok);
        // Lands between the unrestarted and the restarted second
        wait_clk(60300);
        push3(24'h0);
        host.rd(1'b0, 3, ok);
        wait_clk(3000);
        push3(24'h1);
        host.rd(1'b0, 3, ok);
        host.wr_set(val ^ 16'h0005, ok);
        push3(24'h0);
        host.rd(1'b0, 3, ok);
        check("read acks", 1'b1, ok);
        complete_run;
    end
endmodule
`default_nettype wire
